// File: icp_pkg.sv
// Purpose: Shared constants for the interrupt controller tail block.
// Assumes: 32-bit AHB-Lite register bus, 16-bit registers in the low half of each word.
// Notes:   Offsets are word indices; the byte address is four times the index.
`default_nettype none
package icp_pkg;
	// --------------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------------
	localparam logic [7:0]  IDX_CTRL      = 8'h1D; // Control register index.
	localparam logic [7:0]  IDX_CAN2_PRIO = 8'h1F; // CAN-2 priority index.
	localparam logic [7:0]  IDX_IRQ_STAT  = 8'h20; // Sticky event status index.
	localparam logic [7:0]  IDX_IRQ_MASK  = 8'h21; // Event mask index.
	// Control register fields.
	localparam int          CTRL_EDGE_A   = 0;     // Pin A edge select.
	localparam int          CTRL_EDGE_B   = 1;     // Pin B edge select.
	localparam int          CTRL_LVL_A    = 2;     // Pin A level, read only.
	localparam int          CTRL_LVL_B    = 3;     // Pin B level, read only.
	localparam int          CTRL_RSVD_ONE = 4;     // Reads as one.
	localparam int          CTRL_DIS      = 5;     // Global disable.
	localparam int          CTRL_INT      = 15;    // Request to the core.
	// CAN-2 priority field positions (low bit of each pair).
	localparam int          PRIO_BOFF     = 0;
	localparam int          PRIO_ERR      = 2;
	localparam int          PRIO_WKUP     = 4;
	localparam int          PRIO_MSGBUF   = 6;
	localparam logic [7:0]  CAN2_PRIO_RST = 8'h00; // All fields disabled.
	localparam logic [1:0]  CTRL_EDGE_RST = 2'h0;  // Both pins level sensitive.
	localparam logic [1:0]  PRIO_OFF      = 2'h0;  // Disabled encoding.
	// Event status bits: one per external pin.
	localparam int          EVT_W         = 2;
	localparam logic [EVT_W-1:0] EVT_RST  = 2'h0;
	// Vectors presented to the core.
	localparam logic [6:0]  VEC_RESET     = 7'h00; // Reset vector number.
	localparam logic [6:0]  VEC_EXT_A     = 7'h41; // Pin A vector.
	localparam logic [6:0]  VEC_EXT_B     = 7'h42; // Pin B vector.
	localparam logic [6:0]  VEC_CAN2_BASE = 7'h50; // Msgbuf, wake, err, boff follow.
	localparam int          RST_VEC_HOLD  = 2;     // Edges after release.
	// Arbiter states.
	typedef enum logic [1:0] {
		ICP_IDLE = 2'b01,
		ICP_REQ  = 2'b10
	} icp_state_t;
endpackage
`default_nettype wire

// File: icp_ctrl.sv
// Purpose: External pin sense, CAN-2 priorities, reset vector and core request.
// Assumes: Pins and sources synchronous to hclk; core pulses irq_taken once per accept.
// Notes:   Core fixed-priority requests are passed through; only the global disable masks them.
`default_nettype none
module icp_ctrl
	import icp_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_int_a_pin,   // Active low pin A.
	input  wire logic        ext_int_b_pin,   // Active low pin B.
	input  wire logic        stop_wait_mode,  // High in Stop or Wait.
	input  wire logic [3:0]  can2_src,        // Msgbuf, wake, err, boff levels (3..0).
	input  wire logic        core_fixed_req,  // Any fixed-priority core request.
	input  wire logic        irq_taken,       // Core accepted the request.
	output logic             irq_to_core,     // Request to the core.
	output logic      [1:0]  priority_level,  // Level of the request.
	output logic      [6:0]  vector_num,      // Vector number to the core.
	output logic             irq_out          // Event interrupt output.
);
	// --------------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------------
	logic [1:0]       edge_sel;      // Bit 1 pin B, bit 0 pin A.
	logic             global_int_disable;
	logic [7:0]       can2_prio;     // Four priority fields.
	logic [1:0]       pin_q;         // Previous pin levels.
	logic [1:0]       edge_latch;    // Pending falling edges.
	logic [EVT_W-1:0] evt_stat;      // Sticky events.
	logic [EVT_W-1:0] evt_mask;      // Event mask.
	logic [1:0]       rst_cnt;       // Edges since reset release.
	icp_state_t       state;
	logic             ap_valid;      // Data phase pending.
	logic             ap_write;
	logic [7:0]       ap_idx;

	// Decode a 2-bit priority code: valid flag and level 0..2.
	function automatic logic [2:0] prio_decode(input logic [1:0] code);
		// zero disables, otherwise level is code minus one
		if (code == PRIO_OFF) begin
			prio_decode = 3'h0;
		end else begin
			prio_decode = {1'b1, code - 2'h1};
		end
	endfunction

	// --------------------------------------------------------------------
	// Pin sensing
	// --------------------------------------------------------------------
	logic [1:0] pins;
	logic [1:0] fall;
	logic [1:0] ext_req;
	assign pins = {ext_int_b_pin, ext_int_a_pin};
	assign fall = pin_q & ~pins;
	// edge select, forced to level in low power
	assign ext_req = (edge_sel & {2{~stop_wait_mode}} & edge_latch)
		| (~(edge_sel & {2{~stop_wait_mode}}) & ~pins);

	// Previous level keeps the edge detector honest across reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_q <= 2'h3;
		end else begin
			pin_q <= pins;
		end
	end

	// Edge latches; a new edge wins over clearance by the core.
	logic [1:0] take_ext;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_latch <= 2'h0;
		end else begin
			edge_latch <= (edge_latch & ~take_ext) | (fall & edge_sel);
		end
	end

	// --------------------------------------------------------------------
	// Request arbitration
	// --------------------------------------------------------------------
	logic [2:0] dm, dw, de, db;
	assign dm = prio_decode(can2_prio[PRIO_MSGBUF +: 2]);
	assign dw = prio_decode(can2_prio[PRIO_WKUP +: 2]);
	assign de = prio_decode(can2_prio[PRIO_ERR +: 2]);
	assign db = prio_decode(can2_prio[PRIO_BOFF +: 2]);

	logic       next_req;
	logic [1:0] next_lvl;
	logic [6:0] next_vec;
	// Fixed request, then pin A, pin B, then the highest CAN-2 level; ties go to the lower vector.
	always_comb begin
		next_req = 1'b0;
		next_lvl = 2'h0;
		next_vec = VEC_RESET;
		if (core_fixed_req) begin
			// fixed core requests are masked only by the global disable
			next_req = 1'b1;
			next_lvl = 2'h3;
			next_vec = VEC_RESET + 7'h1;
		end else if (ext_req[0]) begin
			next_req = 1'b1;
			next_vec = VEC_EXT_A;
		end else if (ext_req[1]) begin
			next_req = 1'b1;
			next_vec = VEC_EXT_B;
		end else begin
			// only enabled CAN-2 fields may request
			if (can2_src[3] && dm[2] && (!next_req || dm[1:0] > next_lvl)) begin
				next_req = 1'b1;
				next_lvl = dm[1:0];
				next_vec = VEC_CAN2_BASE;
			end
			if (can2_src[2] && dw[2] && (!next_req || dw[1:0] > next_lvl)) begin
				next_req = 1'b1;
				next_lvl = dw[1:0];
				next_vec = VEC_CAN2_BASE + 7'h1;
			end
			if (can2_src[1] && de[2] && (!next_req || de[1:0] > next_lvl)) begin
				next_req = 1'b1;
				next_lvl = de[1:0];
				next_vec = VEC_CAN2_BASE + 7'h2;
			end
			if (can2_src[0] && db[2] && (!next_req || db[1:0] > next_lvl)) begin
				next_req = 1'b1;
				next_lvl = db[1:0];
				next_vec = VEC_CAN2_BASE + 7'h3;
			end
		end
		if (global_int_disable) begin
			next_req = 1'b0;
		end
	end

	assign take_ext = {irq_taken && state == ICP_REQ && vector_num == VEC_EXT_B,
		irq_taken && state == ICP_REQ && vector_num == VEC_EXT_A};

	// Count edges after release so the reset vector stands long enough.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_cnt <= 2'h0;
		end else if (rst_cnt != 2'(RST_VEC_HOLD)) begin
			rst_cnt <= rst_cnt + 2'h1;
		end
	end

	// Request state machine; outputs registered.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state          <= ICP_IDLE;
			irq_to_core    <= 1'b0;
			priority_level <= 2'h0;
			vector_num     <= VEC_RESET;
		end else if (rst_cnt != 2'(RST_VEC_HOLD)) begin
			// reset vector held through the second edge
			vector_num <= VEC_RESET;
		end else begin
			case (state)
				ICP_IDLE: begin
					if (next_req) begin
						state          <= ICP_REQ;
						irq_to_core    <= 1'b1;
						priority_level <= next_lvl;
						vector_num     <= next_vec;
					end
				end
				ICP_REQ: begin
					// Drop after acceptance, or if the source vanished.
					if (irq_taken || !next_req) begin
						state       <= ICP_IDLE;
						irq_to_core <= 1'b0;
					end
				end
				default: begin
					state <= ICP_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------------------------
	// AHB-Lite slave: zero wait states, always OKAY
	// --------------------------------------------------------------------
	logic       wr_en;
	logic [7:0] wr_idx;
	assign wr_en  = ap_valid && ap_write;
	assign wr_idx = ap_idx;

	// Capture the address phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_idx   <= 8'h00;
		end else if (hready) begin
			ap_valid <= hsel && htrans[1];
			ap_write <= hwrite;
			ap_idx   <= haddr[9:2];
		end
	end

	// Control register writes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			edge_sel           <= CTRL_EDGE_RST;
			global_int_disable <= 1'b0;
		end else if (wr_en && wr_idx == IDX_CTRL) begin
			edge_sel           <= {hwdata[CTRL_EDGE_B], hwdata[CTRL_EDGE_A]};
			global_int_disable <= hwdata[CTRL_DIS];
		end
	end

	// CAN-2 priority writes; the upper byte is never stored.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			can2_prio <= CAN2_PRIO_RST;
		end else if (wr_en && wr_idx == IDX_CAN2_PRIO) begin
			// fields sit in the low byte
			can2_prio <= hwdata[7:0];
		end
	end

	// Sticky events: falling edges on pins; set wins over write-one clear.
	logic [EVT_W-1:0] clr;
	assign clr = (wr_en && wr_idx == IDX_IRQ_STAT) ? hwdata[EVT_W-1:0] : EVT_RST;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt_stat <= EVT_RST;
			evt_mask <= EVT_RST;
			irq_out  <= 1'b0;
		end else begin
			evt_stat <= (evt_stat & ~clr) | fall;
			if (wr_en && wr_idx == IDX_IRQ_MASK) begin
				evt_mask <= hwdata[EVT_W-1:0];
			end
			irq_out <= |(((evt_stat & ~clr) | fall) & evt_mask);
		end
	end

	// Read data is prepared in the address phase and registered.
	logic [31:0] next_rdata;
	logic [7:0]  ridx;
	assign ridx = haddr[9:2];
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (ridx == IDX_CTRL) begin
			next_rdata[CTRL_INT]      = irq_to_core;
			next_rdata[14:13]         = priority_level;
			next_rdata[12:6]          = vector_num;
			next_rdata[CTRL_DIS]      = global_int_disable;
			next_rdata[CTRL_RSVD_ONE] = 1'b1;
			next_rdata[CTRL_LVL_B]    = ext_int_b_pin;
			next_rdata[CTRL_LVL_A]    = ext_int_a_pin;
			next_rdata[CTRL_EDGE_B]   = edge_sel[1];
			next_rdata[CTRL_EDGE_A]   = edge_sel[0];
		end else if (ridx == IDX_CAN2_PRIO) begin
			next_rdata[7:0] = can2_prio;
		end else if (ridx == IDX_IRQ_STAT) begin
			next_rdata[EVT_W-1:0] = evt_stat;
		end else if (ridx == IDX_IRQ_MASK) begin
			next_rdata[EVT_W-1:0] = evt_mask;
		end
	end

	// Registered read data and fixed handshake.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	property p_rst_vec;
		@(posedge hclk) $rose(hresetn) |-> vector_num == VEC_RESET ##1 vector_num == VEC_RESET;
	endproperty
	a_rst_vec: assert property (p_rst_vec) else $error("reset vector dropped early");

	property p_dis;
		@(posedge hclk) disable iff (!hresetn)
		global_int_disable && $past(global_int_disable) && state == ICP_IDLE |=> !irq_to_core;
	endproperty
	a_dis: assert property (p_dis) else $error("request while disabled");

	// A read of the CAN-2 priority register must never show its upper byte.
	property p_prio_hi;
		@(posedge hclk) disable iff (!hresetn)
		$past(hready && hsel && htrans[1] && !hwrite && haddr[9:2] == IDX_CAN2_PRIO)
		|-> hrdata[15:8] == 8'h00;
	endproperty
	a_prio_hi: assert property (p_prio_hi) else $error("CAN-2 upper byte not zero");

	property p_can_off;
		@(posedge hclk) disable iff (!hresetn)
		irq_to_core && vector_num >= VEC_CAN2_BASE |-> priority_level != 2'h3;
	endproperty
	a_can_off: assert property (p_can_off) else $error("CAN-2 reached level 3");

	property p_edge_hold;
		@(posedge hclk) disable iff (!hresetn)
		edge_latch[0] && !take_ext[0] |=> edge_latch[0];
	endproperty
	a_edge_hold: assert property (p_edge_hold) else $error("edge lost before taken");

	// Every pin held low must request in low power, whatever its edge select holds.
	property p_level;
		@(posedge hclk) disable iff (!hresetn)
		stop_wait_mode |-> &(ext_req | pins);
	endproperty
	a_level: assert property (p_level) else $error("pin not level in low power");

	property p_fixed;
		@(posedge hclk) disable iff (!hresetn)
		rst_cnt == 2'(RST_VEC_HOLD) && state == ICP_IDLE && core_fixed_req
		&& !global_int_disable |=> irq_to_core && priority_level == 2'h3;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed request not raised");

	property p_edge_a;
		@(posedge hclk) disable iff (!hresetn)
		edge_sel[0] && $fell(ext_int_a_pin) |=> edge_latch[0] || $past(take_ext[0]);
	endproperty
	a_edge_a: assert property (p_edge_a) else $error("pin A edge not latched");

	property p_can_rst;
		@(posedge hclk) $rose(hresetn) |-> can2_prio == CAN2_PRIO_RST && edge_sel == 2'h0;
	endproperty
	a_can_rst: assert property (p_can_rst) else $error("bad reset defaults");
endmodule
`default_nettype wire

// File: icp_core_model.sv
// Purpose: Behavioural processor core that accepts interrupt requests.
// Assumes: Request and vector are registered outputs of the controller.
// Notes:   A slow core: it lets a request stand LAT+1 cycles before taking it.
`default_nettype none
module icp_core_model
	import icp_pkg::*;
#(
	parameter int LAT = 3
)(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       irq_to_core,
	input  wire logic [6:0] vector_num,
	output var  logic       irq_taken,
	output var  logic [6:0] last_vec,
	output var  int         takes
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Acceptance
	// ------------------------------------------------------------
	int wait_cnt; // Cycles the present request has stood.
	// One pulse per accept, then the count restarts so a level source
	// that stays active is taken again, as a real core would.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_cnt <= 0;
			irq_taken <= 1'b0;
			last_vec <= 7'h00;
			takes <= 0;
		end else if (irq_taken || !irq_to_core) begin
			irq_taken <= 1'b0;
			wait_cnt <= 0;
		end else if (wait_cnt == LAT) begin
			irq_taken <= 1'b1;
			last_vec <= vector_num;
			takes <= takes + 1;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// File: interrupt_ctrl_ext_pins_can_prio_bench.sv
// Purpose: Self-checking bench for the interrupt controller tail block.
// Assumes: Zero-wait AHB-Lite slave; the core model answers after a delay.
// Notes:   Byte address is four times the word index.
`default_nettype none
module interrupt_ctrl_ext_pins_can_prio_bench
	import icp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [1:0]  ext_pin_n = 2'h3; // Both pins idle high.
	logic        sw = 1'b0;
	logic [3:0]  can2_src = 4'h0;
	logic        fixed = 1'b0;
	logic        irq_taken, req, irq_out;
	logic [1:0]  lvl;
	logic [6:0]  vec, last_vec;
	int          takes, mismatches = 0, checks_done = 0, cycles = 0;

	always #10 hclk = ~hclk;

	icp_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.ext_int_a_pin(ext_pin_n[0]), .ext_int_b_pin(ext_pin_n[1]),
		.stop_wait_mode(sw), .can2_src(can2_src), .core_fixed_req(fixed),
		.irq_taken(irq_taken), .irq_to_core(req), .priority_level(lvl),
		.vector_num(vec), .irq_out(irq_out));

	icp_core_model #(.LAT(3)) core (.hclk(hclk), .hresetn(hresetn),
		.irq_to_core(req), .vector_num(vec), .irq_taken(irq_taken),
		.last_vec(last_vec), .takes(takes));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One single transfer; address phase, then data phase, each held to hready.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge hclk);
		// Only the bench timeout may end a wait for the slave.
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		// The slave must always answer OKAY.
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask

	task automatic rdm(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, idx, 32'h0, x);
		chk(x & m, e);
	endtask

	// Waits a bounded time for a request, then checks level and vector.
	task automatic wait_req(input logic [6:0] v, input logic [1:0] l);
		int n;
		for (n = 0; n < 30 && req !== 1'b1; n++) @(posedge hclk);
		chk({22'h0, req, lvl, vec}, {22'h0, 1'b1, l, v});
	endtask

	task automatic no_req(input int n);
		repeat (n) begin
			@(posedge hclk);
			chk({31'h0, req}, 32'h0);
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rdm(IDX_CTRL, 32'h3F, 32'h1C);
		rdm(IDX_CAN2_PRIO, 32'hFFFF, 32'h0);
		wr(IDX_CAN2_PRIO, 32'hFFFF);
		rdm(IDX_CAN2_PRIO, 32'hFFFF, 32'hFF);
		wr(IDX_CAN2_PRIO, 32'hE4);
		rdm(IDX_CAN2_PRIO, 32'hFFFF, 32'hE4);
		wr(8'h1E, 32'hFFFF);
		rdm(8'h1E, 32'hFFFFFFFF, 32'h0);
		$display("test registers done");
	endtask

	// Every encoding of every field, then priority between fields.
	task automatic t_can2();
		int f, e;
		for (f = 0; f < 4; f++)
			for (e = 0; e < 4; e++) begin
				wr(IDX_CAN2_PRIO, 32'(e) << (2 * f));
				can2_src <= 4'(1 << f);
				if (e == 0)
					no_req(6);
				else
					wait_req(VEC_CAN2_BASE + 7'(3 - f), 2'(e - 1));
				can2_src <= 4'h0;
				repeat (6) @(posedge hclk);
			end
		wr(IDX_CAN2_PRIO, 32'h1B);
		can2_src <= 4'hF;
		wait_req(VEC_CAN2_BASE + 7'h3, 2'h2);
		// Let the standing request go before the priorities change.
		can2_src <= 4'h0;
		repeat (6) @(posedge hclk);
		wr(IDX_CAN2_PRIO, 32'hFF);
		can2_src <= 4'hF;
		wait_req(VEC_CAN2_BASE, 2'h2);
		can2_src <= 4'h0;
		wr(IDX_CAN2_PRIO, 32'h0);
		$display("test priority fields done");
	endtask

	// Level sense, then a one-cycle falling edge with status and mask.
	task automatic t_pins();
		int p;
		for (p = 0; p < 2; p++) begin
			ext_pin_n[p] <= 1'b0;
			wait_req(VEC_EXT_A + 7'(p), 2'h0);
			rdm(IDX_CTRL, 32'hC, 32'(4'hC ^ (4 << p)));
			ext_pin_n[p] <= 1'b1;
			repeat (6) @(posedge hclk);
			wr(IDX_IRQ_STAT, 32'h3);
			wr(IDX_IRQ_MASK, 32'h3);
			wr(IDX_CTRL, 32'(1 << p));
			ext_pin_n[p] <= 1'b0;
			@(posedge hclk);
			ext_pin_n[p] <= 1'b1;
			wait_req(VEC_EXT_A + 7'(p), 2'h0);
			// The request stands until the core takes it; only then must it stay quiet.
			repeat (6) @(posedge hclk);
			no_req(6);
			rdm(IDX_IRQ_STAT, 32'h3, 32'(1 << p));
			repeat (2) @(posedge hclk);
			chk({31'h0, irq_out}, 32'h1);
			wr(IDX_IRQ_MASK, 32'h0);
			repeat (2) @(posedge hclk);
			chk({31'h0, irq_out}, 32'h0);
			wr(IDX_IRQ_MASK, 32'h3);
			wr(IDX_IRQ_STAT, 32'(1 << p));
			repeat (2) @(posedge hclk);
			chk({31'h0, irq_out}, 32'h0);
			rdm(IDX_IRQ_STAT, 32'h3, 32'h0);
			wr(IDX_CTRL, 32'h0);
		end
		$display("test pins done");
	endtask

	// A pin held low: taken once when edge sensing, repeatedly in Stop/Wait.
	task automatic t_stop();
		int k;
		wr(IDX_CTRL, 32'h3);
		k = takes;
		ext_pin_n[1] <= 1'b0;
		repeat (40) @(posedge hclk);
		chk(32'(takes - k), 32'h1);
		sw <= 1'b1;
		k = takes;
		repeat (40) @(posedge hclk);
		chk({31'h0, (takes - k) > 1}, 32'h1);
		ext_pin_n[1] <= 1'b1;
		sw <= 1'b0;
		repeat (6) @(posedge hclk);
		wr(IDX_CTRL, 32'h0);
		wr(IDX_IRQ_STAT, 32'h3);
		$display("test stop wait done");
	endtask

	task automatic t_dis();
		wr(IDX_CTRL, 32'h20);
		ext_pin_n[0] <= 1'b0;
		fixed <= 1'b1;
		no_req(10);
		rdm(IDX_CTRL, 32'h20, 32'h20);
		wr(IDX_CTRL, 32'h0);
		wait_req(7'h01, 2'h3);
		fixed <= 1'b0;
		ext_pin_n[0] <= 1'b1;
		repeat (6) @(posedge hclk);
		wr(IDX_IRQ_STAT, 32'h3);
		$display("test disable done");
	endtask

	// Mid-run reset with a fixed request standing.
	task automatic t_rst();
		wr(IDX_CAN2_PRIO, 32'hFF);
		wr(IDX_CTRL, 32'h23);
		fixed <= 1'b1;
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({22'h0, req, lvl, vec}, 32'h0);
		hresetn <= 1'b1;
		@(posedge hclk);
		repeat (2) begin
			@(posedge hclk);
			chk({25'h0, vec}, 32'h0);
		end
		wait_req(7'h01, 2'h3);
		fixed <= 1'b0;
		rdm(IDX_CAN2_PRIO, 32'hFFFF, 32'h0);
		rdm(IDX_CTRL, 32'h3F, 32'h1C);
		$display("test reset done");
	endtask

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Cuts a hang short; the run needs well under this many cycles.
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			results();
		end
	end

	initial begin
		repeat (20) @(posedge hclk);
		chk({22'h0, req, lvl, vec}, 32'h0);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_can2();
		t_pins();
		t_stop();
		t_dis();
		t_rst();
		results();
	end
endmodule
`default_nettype wire
